// ---- verilog/tdw_pkg.sv ----
// Package for the travel distance wear monitor
package tdw_pkg;
	localparam int          DATA_W        = 32;
	localparam int          ADDR_W        = 4;
	localparam int          DIST_W        = 36;
	localparam int          SEL_W         = 2;
	// Register byte addresses
	localparam logic [3:0]  ADDR_SELECT   = 4'h0;
	localparam logic [3:0]  ADDR_THRESH   = 4'h4;
	localparam logic [3:0]  ADDR_OFFSET   = 4'h8;
	localparam logic [3:0]  ADDR_TOTAL    = 4'hC;
	localparam logic [3:0]  ADDR_STATUS   = 4'h1;
	localparam logic [3:0]  ADDR_MASK     = 4'h2;
	// Selection codes
	localparam logic [1:0]  SEL_OFF       = 2'h0;
	localparam logic [1:0]  SEL_ON        = 2'h1;
	localparam logic [1:0]  SEL_CLEAR     = 2'h2;
	// Reset values and revolution total ceiling
	localparam logic [31:0] THRESH_RST    = 32'h0;
	localparam logic [31:0] OFFSET_RST    = 32'h0;
	localparam logic [35:0] DIST_MAX      = 36'hFFFFFFFFF;
	// Feedback counts per ten revolutions
	localparam logic [15:0] COUNTS_PER_UNIT = 16'h000A;
	// Status bit positions and width
	localparam int          ST_WARN_SET   = 0;
	localparam int          ST_WARN_CLR   = 1;
	localparam int          ST_CLEARED    = 2;
	localparam int          ST_W          = 3;
endpackage : tdw_pkg

// ---- verilog/tdw_monitor.sv ----
// Travel distance wear monitor with register port and interrupt
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// (R1) Select value 1 starts comparing travel total against the threshold.
// (R2) While enabled, warning rises once total exceeds threshold.
// (R3) Writing a threshold above the total drops the warning.
// (R4) Writing select 0 drops the warning and stops prediction.
// (R5) Select 2 clears the total at the next restart.
// (R6) After that clear the select field becomes 1 again.
// (R7) That clear also removes an active warning.
// (R8) Software copies the old total into offset after drive exchange.
// (R9) If unreadable, software writes 0 or last known total to offset.
// (R10) Total is kept in the drive, motor or encoder swap needs nothing.
// (R11) Reported total includes the programmed offset.
// (R12) Threshold 0 suppresses the warning entirely.
// (R13) Threshold and offset are in ten-revolution units, reset to zero.
// (R14) The total saturates at its maximum instead of wrapping.
module tdw_monitor
	import tdw_pkg::*;
(
	input  wire logic                    i_clock,        // System clock, 10 MHz
	input  wire logic                    i_rstn,         // Async reset, active low
	input  wire logic                    i_restart,      // Software or controller restart pulse
	input  wire logic                    i_rev_tick,     // One revolution of travel, pulse
	input  wire logic [tdw_pkg::ADDR_W-1:0] i_addr,      // Register byte address
	input  wire logic [tdw_pkg::DATA_W-1:0] i_wdata,     // Write data
	input  wire logic                    i_wr,           // Write strobe
	input  wire logic                    i_rd,           // Read strobe
	output logic      [tdw_pkg::DATA_W-1:0] o_rdata,     // Read data, next cycle
	output logic                         o_travel_wear_warning, // Wear warning level
	output logic                         o_irq           // Interrupt, level
);
	import tdw_pkg::*;

	logic [SEL_W-1:0]  wear_prediction_select_reg;
	logic [DATA_W-1:0] wear_distance_threshold_reg;
	logic [DATA_W-1:0] travel_total_offset_reg;
	logic [DIST_W-1:0] dist_reg;          // Total in revolutions
	logic [15:0]       rev_cnt_reg;       // Revolutions within a unit
	logic [DATA_W-1:0] units_reg;         // Total in ten-revolution units
	logic [ST_W-1:0]   status_reg;
	logic [ST_W-1:0]   mask_reg;
	logic              warn_reg;
	logic              warn_next;
	logic              clear_now;
	logic [DATA_W:0]   total_sum;
	logic [DATA_W-1:0] total_report;

	// Address match helper used by both write and read decode
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		hit = (a == b);
	endfunction

	// Pending clear fires on a restart while select holds 2
	assign clear_now = i_restart && (wear_prediction_select_reg == SEL_CLEAR); // [R5]

	// Selection field register
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			wear_prediction_select_reg <= SEL_OFF;
		end else if (clear_now) begin
			wear_prediction_select_reg <= SEL_ON; // [R6]
		end else if (i_wr && hit(i_addr, ADDR_SELECT)) begin
			wear_prediction_select_reg <= i_wdata[SEL_W-1:0];
		end
	end

	// Threshold and offset settings, ten-revolution units
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			wear_distance_threshold_reg <= THRESH_RST; // [R13]
			travel_total_offset_reg     <= OFFSET_RST; // [R13]
		end else if (i_wr) begin
			if (hit(i_addr, ADDR_THRESH)) begin
				wear_distance_threshold_reg <= i_wdata;
			end else if (hit(i_addr, ADDR_OFFSET)) begin
				travel_total_offset_reg <= i_wdata;
			end
		end
	end

	// Travel accumulator held inside the drive; restart alone keeps it
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			dist_reg    <= '0;
			rev_cnt_reg <= '0;
			units_reg   <= '0;
		end else if (clear_now) begin
			dist_reg    <= '0; // [R5] [R10]
			rev_cnt_reg <= '0;
			units_reg   <= '0;
		end else if (i_rev_tick && dist_reg != DIST_MAX) begin
			dist_reg <= dist_reg + 36'h1; // [R14]
			if (rev_cnt_reg == COUNTS_PER_UNIT - 16'h1) begin
				rev_cnt_reg <= '0;
				if (units_reg != {DATA_W{1'b1}}) begin
					units_reg <= units_reg + 32'h1; // [R13] [R14]
				end
			end else begin
				rev_cnt_reg <= rev_cnt_reg + 16'h1;
			end
		end
	end

	// Warning compare, live against current settings
	always_comb begin
		warn_next = (wear_prediction_select_reg == SEL_ON) // [R1] [R4]
			&& (wear_distance_threshold_reg != '0)          // [R12]
			&& (units_reg > wear_distance_threshold_reg)    // [R2] [R3]
			&& !clear_now;                                  // [R7]
	end

	// Warning flag register
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			warn_reg <= 1'b0;
		end else begin
			warn_reg <= warn_next;
		end
	end
	assign o_travel_wear_warning = warn_reg;

	// Reported total with offset, saturated
	assign total_sum    = {1'b0, units_reg} + {1'b0, travel_total_offset_reg}; // [R11]
	assign total_report = total_sum[DATA_W] ? {DATA_W{1'b1}} : total_sum[DATA_W-1:0]; // [R14]

	// Sticky event status; set wins over read clear
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			status_reg <= '0;
		end else begin
			status_reg <= ((i_rd && hit(i_addr, ADDR_STATUS)) ? '0 : status_reg)
				| {clear_now, warn_reg & ~warn_next, warn_next & ~warn_reg};
		end
	end

	// Interrupt mask
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			mask_reg <= '0;
		end else if (i_wr && hit(i_addr, ADDR_MASK)) begin
			mask_reg <= i_wdata[ST_W-1:0];
		end
	end
	assign o_irq = |(status_reg & mask_reg);

	// Read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			if (hit(i_addr, ADDR_SELECT)) begin
				o_rdata <= {{(DATA_W-SEL_W){1'b0}}, wear_prediction_select_reg};
			end else if (hit(i_addr, ADDR_THRESH)) begin
				o_rdata <= wear_distance_threshold_reg;
			end else if (hit(i_addr, ADDR_OFFSET)) begin
				o_rdata <= travel_total_offset_reg;
			end else if (hit(i_addr, ADDR_TOTAL)) begin
				o_rdata <= total_report; // [R11]
			end else if (hit(i_addr, ADDR_STATUS)) begin
				o_rdata <= {{(DATA_W-ST_W){1'b0}}, status_reg};
			end else if (hit(i_addr, ADDR_MASK)) begin
				o_rdata <= {{(DATA_W-ST_W){1'b0}}, mask_reg};
			end else begin
				o_rdata <= '0;
			end
		end else begin
			o_rdata <= '0;
		end
	end

	// Checks
	sequence s_clear_req;
		i_restart && wear_prediction_select_reg == SEL_CLEAR;
	endsequence
	sequence s_cleared;
		units_reg == '0 && wear_prediction_select_reg == SEL_ON && !warn_reg;
	endsequence
	// Threshold write that lifts the limit above the total
	sequence s_thr_above;
		i_wr && i_addr == ADDR_THRESH && i_wdata > units_reg;
	endsequence
	// Select write that turns prediction off
	sequence s_sel_off;
		i_wr && i_addr == ADDR_SELECT && i_wdata[SEL_W-1:0] == SEL_OFF && !clear_now;
	endsequence

	property p_enable_warn;
		@(posedge i_clock) disable iff (!i_rstn)
		(wear_prediction_select_reg == SEL_ON && wear_distance_threshold_reg != '0
		 && units_reg > wear_distance_threshold_reg && !i_restart) |=> warn_reg;
	endproperty
	a_enable_warn: assert property (p_enable_warn) else $error("warning missing"); // [R1] [R2]

	property p_thresh_drop;
		@(posedge i_clock) disable iff (!i_rstn)
		s_thr_above |-> ##2 !warn_reg;
	endproperty
	a_thresh_drop: assert property (p_thresh_drop) else $error("warning stuck"); // [R3]

	property p_off;
		@(posedge i_clock) disable iff (!i_rstn)
		wear_prediction_select_reg == SEL_OFF |=> !warn_reg;
	endproperty
	a_off: assert property (p_off) else $error("warning while off"); // [R4]

	property p_clear;
		@(posedge i_clock) disable iff (!i_rstn)
		s_clear_req |=> s_cleared;
	endproperty
	a_clear: assert property (p_clear) else $error("clear incomplete"); // [R5] [R6] [R7]

	property p_zero_thresh;
		@(posedge i_clock) disable iff (!i_rstn)
		$past(wear_distance_threshold_reg) == '0 |-> !warn_reg;
	endproperty
	a_zero_thresh: assert property (p_zero_thresh) else $error("warning at zero threshold"); // [R12]

	property p_report;
		@(posedge i_clock) disable iff (!i_rstn)
		i_rd && i_addr == ADDR_TOTAL && !total_sum[DATA_W] |=> o_rdata == $past(total_sum[DATA_W-1:0]);
	endproperty
	a_report: assert property (p_report) else $error("total without offset"); // [R11]

	property p_keep;
		@(posedge i_clock) disable iff (!i_rstn)
		!clear_now && !i_rev_tick |=> units_reg == $past(units_reg);
	endproperty
	a_keep: assert property (p_keep) else $error("total lost"); // [R10]

	property p_sat;
		@(posedge i_clock) disable iff (!i_rstn)
		!clear_now |=> units_reg >= $past(units_reg);
	endproperty
	a_sat: assert property (p_sat) else $error("total wrapped"); // [R14]

	property p_units;
		@(posedge i_clock) disable iff (!i_rstn)
		i_rev_tick && !clear_now && rev_cnt_reg == COUNTS_PER_UNIT - 16'h1
		&& units_reg != {DATA_W{1'b1}} && dist_reg != DIST_MAX |=> units_reg == $past(units_reg) + 32'h1;
	endproperty
	a_units: assert property (p_units) else $error("unit step wrong"); // [R13]

	// Select write of zero drops the warning two edges later
	property p_sel_drop;
		@(posedge i_clock) disable iff (!i_rstn)
		s_sel_off |-> ##2 !warn_reg;
	endproperty
	a_sel_drop: assert property (p_sel_drop) else $error("warning after disable"); // [R4]

	// Warning only follows an enabled select field
	property p_warn_enabled;
		@(posedge i_clock) disable iff (!i_rstn)
		warn_reg |-> $past(wear_prediction_select_reg) == SEL_ON;
	endproperty
	a_warn_enabled: assert property (p_warn_enabled) else $error("warning not enabled"); // [R1]

	// Warning only follows a total above the threshold
	property p_warn_above;
		@(posedge i_clock) disable iff (!i_rstn)
		warn_reg |-> $past(units_reg) > $past(wear_distance_threshold_reg);
	endproperty
	a_warn_above: assert property (p_warn_above) else $error("warning below limit"); // [R2]

	// Rising warning leaves its status bit set
	property p_rise_status;
		@(posedge i_clock) disable iff (!i_rstn)
		$rose(warn_reg) |-> status_reg[ST_WARN_SET];
	endproperty
	a_rise_status: assert property (p_rise_status) else $error("rise not flagged"); // [R2]

	// Falling warning leaves its status bit set
	property p_fall_status;
		@(posedge i_clock) disable iff (!i_rstn)
		$fell(warn_reg) |-> status_reg[ST_WARN_CLR];
	endproperty
	a_fall_status: assert property (p_fall_status) else $error("fall not flagged"); // [R3]

	// Total clear leaves its status bit set
	property p_clear_status;
		@(posedge i_clock) disable iff (!i_rstn)
		s_clear_req |=> status_reg[ST_CLEARED];
	endproperty
	a_clear_status: assert property (p_clear_status) else $error("clear not flagged"); // [R5]

	// Status read with no new event empties the register
	property p_status_rc;
		@(posedge i_clock) disable iff (!i_rstn)
		i_rd && i_addr == ADDR_STATUS && !clear_now && warn_reg == warn_next |=> status_reg == '0;
	endproperty
	a_status_rc: assert property (p_status_rc) else $error("status not cleared");

	// Read data stand one cycle only
	property p_rd_idle;
		@(posedge i_clock) disable iff (!i_rstn)
		!i_rd |=> o_rdata == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stale read data");

	// Revolution counter stays inside one unit
	property p_rev_range;
		@(posedge i_clock) disable iff (!i_rstn)
		rev_cnt_reg < COUNTS_PER_UNIT;
	endproperty
	a_rev_range: assert property (p_rev_range) else $error("unit counter overrun"); // [R13]

	// Revolution counter moves only on a tick
	property p_rev_hold;
		@(posedge i_clock) disable iff (!i_rstn)
		!i_rev_tick && !clear_now |=> rev_cnt_reg == $past(rev_cnt_reg);
	endproperty
	a_rev_hold: assert property (p_rev_hold) else $error("unit counter drift"); // [R13]

	// Revolution total holds at its ceiling
	property p_dist_sat;
		@(posedge i_clock) disable iff (!i_rstn)
		dist_reg == DIST_MAX && !clear_now |=> dist_reg == DIST_MAX;
	endproperty
	a_dist_sat: assert property (p_dist_sat) else $error("revolution total wrapped"); // [R14]

	// Plain restart keeps the stored total
	property p_restart_keep;
		@(posedge i_clock) disable iff (!i_rstn)
		i_restart && wear_prediction_select_reg != SEL_CLEAR && !i_rev_tick
		|=> dist_reg == $past(dist_reg);
	endproperty
	a_restart_keep: assert property (p_restart_keep) else $error("restart lost total"); // [R10]

	// Threshold write lands whole
	property p_thr_write;
		@(posedge i_clock) disable iff (!i_rstn)
		i_wr && i_addr == ADDR_THRESH |=> wear_distance_threshold_reg == $past(i_wdata);
	endproperty
	a_thr_write: assert property (p_thr_write) else $error("threshold not stored"); // [R13]

	// Offset write lands whole
	property p_offset_write;
		@(posedge i_clock) disable iff (!i_rstn)
		i_wr && i_addr == ADDR_OFFSET |=> travel_total_offset_reg == $past(i_wdata);
	endproperty
	a_offset_write: assert property (p_offset_write) else $error("offset not stored"); // [R11]

	// Mask write lands in the mask register
	property p_mask_write;
		@(posedge i_clock) disable iff (!i_rstn)
		i_wr && i_addr == ADDR_MASK |=> mask_reg == $past(i_wdata[ST_W-1:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask not stored");

endmodule : tdw_monitor
`default_nettype wire

// ---- test/tdw_feedback_model.sv ----
// Motion feedback model that sends revolution ticks on request
`timescale 1ns/10ps
`default_nettype none
module tdw_feedback_model (
	input  wire logic       i_clock, // System clock
	input  wire logic       i_rstn,  // Reset, active low
	input  wire logic [7:0] i_count, // Ticks to send
	input  wire logic       i_start, // Load count, pulse
	output logic            o_tick,  // One revolution pulse
	output logic            o_busy   // Ticks still pending
);
	logic [7:0] left_reg;
	// One tick every second cycle until the count runs out
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			left_reg <= 8'h00;
			o_tick   <= 1'b0;
		end else if (i_start) begin
			left_reg <= i_count;
			o_tick   <= 1'b0;
		end else if ((left_reg != 8'h00) && !o_tick) begin
			left_reg <= left_reg - 8'h01;
			o_tick   <= 1'b1;
		end else begin
			o_tick   <= 1'b0;
		end
	end
	// Busy while ticks remain or one is on the line
	assign o_busy = (left_reg != 8'h00) || o_tick;
endmodule // tdw_feedback_model
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking testbench for the travel distance wear monitor
`timescale 1ns/10ps
`default_nettype none
module tb;
	import tdw_pkg::*;
	typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} tdw_row_t;
	logic              i_clock, i_rstn, i_restart, i_wr, i_rd, i_start, tick, busy, warn, irq;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata, rdata, got;
	logic [7:0]        i_count;
	int                num_errors = 0;
	int                checks = 0;
	tdw_row_t          rows [6] = '{'{ADDR_SELECT, 32'h1, 32'h1}, '{ADDR_THRESH, 32'h3, 32'h3},
		'{ADDR_OFFSET, 32'h5, 32'h5}, '{ADDR_MASK, 32'h7, 32'h7},
		'{ADDR_TOTAL, 32'h4D2, 32'h5}, '{4'h3, 32'hAB, 32'h0}};
	tdw_monitor dut_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_restart(i_restart),
		.i_rev_tick(tick), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(rdata), .o_travel_wear_warning(warn), .o_irq(irq));
	tdw_feedback_model fb_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_count(i_count),
		.i_start(i_start), .o_tick(tick), .o_busy(busy));
	// Clock, 100 ns period
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clock);
		i_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clock);
		i_rd   <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Request ticks from the feedback model and wait until sent
	task automatic spin(input logic [7:0] n);
		@(posedge i_clock);
		i_count <= n;
		i_start <= 1'b1;
		@(posedge i_clock);
		i_start <= 1'b0;
		for (int k = 0; k < 600; k++) begin
			@(posedge i_clock);
			#1 if (busy === 1'b0) return;
		end
		num_errors++;
		report_and_stop();
	endtask
	// Let a write take effect on the warning level
	task automatic wrw(input logic [3:0] a, input logic [31:0] d, input logic e, input string n);
		wr(a, d);
		repeat (2) @(posedge i_clock);
		#1 chk(n, {31'h0, warn}, {31'h0, e});
	endtask
	// Main sequence
	initial begin
		{i_rstn, i_restart, i_wr, i_rd, i_start} = 5'h00;
		i_addr  = 4'h0;
		i_wdata = 32'h0;
		i_count = 8'h00;
		repeat (2) @(posedge i_clock);
		i_rstn <= 1'b1;
		rd(ADDR_THRESH, got); chk("thresh rst", got, THRESH_RST);
		rd(ADDR_OFFSET, got); chk("offset rst", got, OFFSET_RST);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, got); chk("row", got, rows[i].e);
		end
		spin(8'd30);
		rd(ADDR_TOTAL, got); chk("total", got, 32'h8);
		chk("warn eq", {31'h0, warn}, 32'h0);
		spin(8'd10);
		repeat (2) @(posedge i_clock);
		#1 chk("warn up", {31'h0, warn}, 32'h1);
		chk("irq up", {31'h0, irq}, 32'h1);
		rd(ADDR_STATUS, got); chk("status", got, 32'h1);
		#1 chk("irq clr", {31'h0, irq}, 32'h0);
		wrw(ADDR_THRESH, 32'hA, 1'b0, "thr big");
		wrw(ADDR_THRESH, 32'h0, 1'b0, "thr zero");
		wrw(ADDR_THRESH, 32'h2, 1'b1, "thr low");
		wrw(ADDR_SELECT, 32'h0, 1'b0, "sel off");
		wrw(ADDR_SELECT, 32'h1, 1'b1, "sel on");
		wr(ADDR_SELECT, {30'h0, SEL_CLEAR});
		@(posedge i_clock);
		i_restart <= 1'b1;
		@(posedge i_clock);
		i_restart <= 1'b0;
		rd(ADDR_TOTAL, got); chk("cleared", got, 32'h5);
		rd(ADDR_SELECT, got); chk("sel back", got, 32'h1);
		chk("warn gone", {31'h0, warn}, 32'h0);
		rd(ADDR_STATUS, got); chk("status2", got, 32'h7);
		wr(ADDR_OFFSET, 32'h0);
		spin(8'd10);
		rd(ADDR_TOTAL, got); chk("offset zero", got, 32'h1);
		// Mid-run power reset clears total and select
		@(posedge i_clock);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_rstn <= 1'b1;
		rd(ADDR_TOTAL, got); chk("total rst", got, 32'h0);
		rd(ADDR_SELECT, got); chk("sel rst", got, 32'h0);
		chk("warn rst", {31'h0, warn}, 32'h0);
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
